// ---- spims_regs.vh ----
// Constants for the SPI master/slave port
`ifndef SPIMS_REGS_VH
`define SPIMS_REGS_VH
// Character length in bits
`define SPIMS_CHAR_BITS   4'h8
// Serial clock half period in system clocks (master mode)
`define SPIMS_HALF_DIV    8'h04
// Reset values
`define SPIMS_RST_BYTE    8'h00
`define SPIMS_RST_CNT     4'h0
// Bit position of the most-significant data bit
`define SPIMS_MSB_POS     7
`endif

// ---- spims_sync.v ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module spims_sync (
	// Clock and reset
	input  wire clk_sys_i,
	input  wire rst_n_i,
	// Asynchronous pin and synchronised copy
	input  wire async_i,
	output reg  sync_o
);
	reg meta_q;

	// First stage feeds only the second stage
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= 1'b0;
			sync_o <= 1'b0;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule // spims_sync

// ---- spims_port.v ----
// SPI master/slave port with four clock modes and mode-fault detection
`timescale 1ns/1ns
`include "spims_regs.vh"
// Function
// - Full-duplex four-wire character link
// - One byte per eight serial clocks
// - Drive one edge, capture opposite edge
// - Slave accepts held or released select
// - Sole master: select pin input or output
// - Select low while master sets mode fault
// - Polarity only sets active clock level
// - Phase selects one of two formats
// - Edge table for four phase/polarity settings
// - Both ends use same phase and polarity
// - Master presents bit half period early
module spims_port (
	// Clock and reset
	input  wire       clk_sys_i,
	input  wire       rst_n_i,
	// Configuration
	input  wire       enable_i,
	input  wire       master_i,
	input  wire       clock_phase_i,
	input  wire       clock_polarity_select_i,
	input  wire       ss_out_en_i,
	input  wire       multi_master_i,
	// Transmit request and receive result
	input  wire       tx_start_i,
	input  wire [7:0] tx_data_i,
	output reg        busy_o,
	output reg        rx_valid_o,
	output reg  [7:0] rx_data_o,
	// Mode fault status
	input  wire       fault_clear_i,
	output reg        mode_fault_o,
	// Serial pins
	input  wire       sck_in_i,
	output reg        sck_out_o,
	output reg        sck_oe_o,
	input  wire       mosi_in_i,
	output reg        mosi_out_o,
	output reg        mosi_oe_o,
	input  wire       miso_in_i,
	output reg        miso_out_o,
	output reg        miso_oe_o,
	input  wire       ss_n_in_i,
	output reg        ss_n_out_o,
	output reg        ss_n_oe_o
);
	////////////////////////////////////////////////////////////////////////
	// Synchronised pin inputs
	wire sck_s;
	wire mosi_s;
	wire miso_s;
	wire sel_s;

	spims_sync u_sync_sck (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.async_i   (sck_in_i),
		.sync_o    (sck_s)
	);
	spims_sync u_sync_mosi (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.async_i   (mosi_in_i),
		.sync_o    (mosi_s)
	);
	spims_sync u_sync_miso (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.async_i   (miso_in_i),
		.sync_o    (miso_s)
	);
	spims_sync u_sync_ss (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.async_i   (~ss_n_in_i),
		.sync_o    (sel_s)
	);
	// Select enters inverted so that the synchronised copy is active high

	////////////////////////////////////////////////////////////////////////
	// Shared state
	localparam ST_IDLE = 2'b00;
	localparam ST_XFER = 2'b01;
	localparam ST_DONE = 2'b10;

	reg [1:0] state_q;
	reg [7:0] shift_q;
	reg [3:0] cnt_q;
	reg [7:0] div_q;
	reg       lead_q;
	reg       sck_d1_q;

	// Slave edge detection on the synchronised clock
	wire sck_rise = sck_s & ~sck_d1_q;
	wire sck_fall = ~sck_s & sck_d1_q;
	// Leading edge leaves idle level; capture on leading edge iff phase 0
	// so polarity only flips which raw edge is meant, not the format
	wire lead_edge  = clock_polarity_select_i ? sck_fall : sck_rise;
	wire trail_edge = clock_polarity_select_i ? sck_rise : sck_fall;
	wire cap_edge   = clock_phase_i ? trail_edge : lead_edge;
	wire drv_edge   = clock_phase_i ? lead_edge : trail_edge;
	wire half_tick  = (div_q == `SPIMS_HALF_DIV - 8'h01);

	wire slave_mode = enable_i & ~master_i;

	// Function: next serial bit is the MSB of the shift register
	function next_bit;
		input [7:0] v;
		next_bit = v[`SPIMS_MSB_POS];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Master and slave engine
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q      <= ST_IDLE;
			shift_q      <= `SPIMS_RST_BYTE;
			cnt_q        <= `SPIMS_RST_CNT;
			div_q        <= 8'h00;
			lead_q       <= 1'b0;
			sck_d1_q     <= 1'b0;
			busy_o       <= 1'b0;
			rx_valid_o   <= 1'b0;
			rx_data_o    <= `SPIMS_RST_BYTE;
			mode_fault_o <= 1'b0;
			sck_out_o    <= 1'b0;
			sck_oe_o     <= 1'b0;
			mosi_out_o   <= 1'b0;
			mosi_oe_o    <= 1'b0;
			miso_out_o   <= 1'b0;
			miso_oe_o    <= 1'b0;
			ss_n_out_o   <= 1'b1;
			ss_n_oe_o    <= 1'b0;
		end else begin
			sck_d1_q   <= sck_s;
			rx_valid_o <= 1'b0;
			// Fault set wins over a clear in the same cycle
			if (enable_i & master_i & multi_master_i & sel_s)
				mode_fault_o <= 1'b1;
			else if (fault_clear_i)
				mode_fault_o <= 1'b0;
			// Pin drivers follow the role; select drives only as sole master
			sck_oe_o  <= enable_i & master_i;
			mosi_oe_o <= enable_i & master_i;
			miso_oe_o <= slave_mode & sel_s;
			ss_n_oe_o <= enable_i & master_i & ss_out_en_i & ~multi_master_i;
			if (!(enable_i & master_i) || state_q == ST_IDLE)
				sck_out_o <= clock_polarity_select_i;
			case (state_q)
				ST_IDLE: begin
					busy_o     <= 1'b0;
					ss_n_out_o <= 1'b1;
					cnt_q      <= `SPIMS_RST_CNT;
					div_q      <= 8'h00;
					lead_q     <= 1'b1;
					if (enable_i & master_i & tx_start_i & ~mode_fault_o) begin
						// Select falls in the same cycle as bit 7 appears; bit 7 is on the line a half period
						// before the first capture edge in phase 0, a full period before it in phase 1
						shift_q    <= tx_data_i;
						mosi_out_o <= next_bit(tx_data_i);
						ss_n_out_o <= 1'b0;
						busy_o     <= 1'b1;
						state_q    <= ST_XFER;
					end else if (slave_mode & sel_s) begin
						shift_q    <= tx_data_i;
						miso_out_o <= next_bit(tx_data_i);
						busy_o     <= 1'b1;
						state_q    <= ST_XFER;
					end
				end
				ST_XFER: begin
					if (master_i) begin
						if (mode_fault_o | ~enable_i) begin
							state_q <= ST_IDLE; // Another master took the bus
						end else if (half_tick) begin
							div_q     <= 8'h00;
							lead_q    <= ~lead_q;
							sck_out_o <= ~sck_out_o;
							if (lead_q ^ clock_phase_i) begin
								// Capture edge of this mode
								shift_q <= {shift_q[6:0], miso_s};
								cnt_q   <= cnt_q + 4'h1;
								if (cnt_q == `SPIMS_CHAR_BITS - 4'h1)
									state_q <= ST_DONE;
							end else if (cnt_q != `SPIMS_RST_CNT || clock_phase_i) begin
								mosi_out_o <= next_bit(shift_q);
							end
						end else begin
							div_q <= div_q + 8'h01;
						end
					end else begin
						// Slave: a select release mid-character aborts it
						if (~sel_s | ~enable_i) begin
							state_q <= ST_IDLE;
						end else if (cap_edge) begin
							shift_q <= {shift_q[6:0], mosi_s};
							cnt_q   <= cnt_q + 4'h1;
							if (cnt_q == `SPIMS_CHAR_BITS - 4'h1)
								state_q <= ST_DONE;
						end else if (drv_edge & (cnt_q != `SPIMS_RST_CNT | clock_phase_i)) begin
							miso_out_o <= next_bit(shift_q);
						end
					end
				end
				ST_DONE: begin
					rx_data_o  <= shift_q;
					rx_valid_o <= 1'b1;
					cnt_q      <= `SPIMS_RST_CNT;
					if (master_i) begin
						// Wait out the trailing half period before releasing select
						if (half_tick) begin
							sck_out_o  <= clock_polarity_select_i;
							ss_n_out_o <= 1'b1;
							state_q    <= ST_IDLE;
						end else begin
							div_q      <= div_q + 8'h01;
							rx_valid_o <= 1'b0;
							rx_data_o  <= rx_data_o;
						end
						if (half_tick)
							rx_data_o <= shift_q;
						if (half_tick)
							rx_valid_o <= 1'b1;
					end else begin
						// Slave may keep select low for back-to-back characters
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end
endmodule // spims_port

// ---- spims_properties.sv ----
// Checker for the SPI master/slave port
`timescale 1ns/1ns
module spims_chk (
	// Clock, reset and configuration
	input logic clk_sys_i, rst_n_i, enable_i, master_i, clock_polarity_select_i,
	input logic ss_out_en_i, multi_master_i, fault_clear_i,
	// Requests and status
	input logic tx_start_i, busy_o, rx_valid_o, mode_fault_o,
	input logic [7:0] tx_data_i,
	// Pins
	input logic ss_n_in_i, sck_out_o, sck_oe_o, mosi_out_o, mosi_oe_o, ss_n_out_o, ss_n_oe_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	property p_idle; $past(rst_n_i) && master_i && $past(master_i) && !busy_o && !$past(busy_o)
		&& $stable(clock_polarity_select_i) |-> sck_out_o == clock_polarity_select_i; endproperty
	a_idle: assert property (p_idle) else $error("sck idle level");
	property p_sel; $rose(busy_o) && master_i && ss_out_en_i && !multi_master_i
		|-> ss_n_oe_o && !ss_n_out_o ##1 !ss_n_out_o [*8]; endproperty
	a_sel: assert property (p_sel) else $error("select not held");
	property p_mm; multi_master_i && $past(multi_master_i) |-> !ss_n_oe_o; endproperty
	a_mm: assert property (p_mm) else $error("select driven");
	property p_flt; (enable_i && master_i && multi_master_i && !ss_n_in_i) [*3]
		|-> ##[0:3] mode_fault_o; endproperty
	a_flt: assert property (p_flt) else $error("no mode fault");
	property p_stk; mode_fault_o && !fault_clear_i |=> mode_fault_o; endproperty
	a_stk: assert property (p_stk) else $error("fault lost");
	property p_go; $past(rst_n_i) && !$past(busy_o) && !busy_o && enable_i && master_i
		&& tx_start_i && !mode_fault_o && !multi_master_i
		|=> busy_o && mosi_out_o == $past(tx_data_i[7]); endproperty
	a_go: assert property (p_go) else $error("start or first bit");
	property p_len; $rose(busy_o) && master_i |-> ##[64:90] rx_valid_o; endproperty
	a_len: assert property (p_len) else $error("byte length");
	property p_sl; !master_i && !$past(master_i) |-> !sck_oe_o && !mosi_oe_o; endproperty
	a_sl: assert property (p_sl) else $error("slave drives");
endmodule // spims_chk
bind spims_port spims_chk i_spims_chk (.*);

// ---- spims_slave_model.sv ----
// Behavioural SPI slave at the far side of the port
`timescale 1ns/1ns
module spims_slave_model (
	// Link pins and mode
	input logic sck_i, ss_n_i, mosi_i, cpha_i, cpol_i,
	// Data
	input logic [7:0] tx_i,
	output logic miso_o,
	output logic [7:0] rx_o
);
	logic [7:0] sh_q;
	int n_q;
	// Capture edge is where the mode-folded clock rises
	wire cap = sck_i ^ cpol_i ^ cpha_i;
	always @(negedge ss_n_i) begin
		sh_q = tx_i;
		n_q = 0;
	end
	// Sample on one edge, shift on the other; none before the first capture
	always @(posedge cap) if (!ss_n_i) begin
		rx_o = {rx_o[6:0], mosi_i};
		n_q++;
	end
	always @(negedge cap) if (!ss_n_i && n_q > 0 && n_q < 8) sh_q = sh_q << 1;
	// Released line shows the inverse so a stale bit cannot pass
	assign miso_o = ss_n_i ? ~sh_q[7] : sh_q[7];
endmodule // spims_slave_model

// ---- tb_top.sv ----
// Self-checking testbench for the SPI master/slave port
`timescale 1ns/1ns
module tb_top;
	logic clk_sys_i = 0, rst_n_i = 0, en = 0, mst = 1, cpha = 0, cpol = 0, mm = 0;
	logic go = 0, fclr = 0, tss_n = 1, tsck = 0, tmosi = 0, soe = 1;
	logic [7:0] txd = 8'h00, stx = 8'h00, rxd, srx;
	logic busy, vld, mf, sck_o, sck_e, mosi_o, mosi_e, miso_o, miso_e, sso_n, sse, smiso;
	int errors = 0, checks_done = 0, nv = 0;
	// Pin levels from every driver; the bench is master in slave mode
	wire ss_n = sse ? sso_n : tss_n;
	wire sck = sck_e ? sck_o : tsck;
	wire mosi = mosi_e ? mosi_o : tmosi;
	wire miso = miso_e ? miso_o : smiso;
	always #10 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) nv <= nv + vld;
	spims_port i_spims_port (.clk_sys_i, .rst_n_i, .enable_i(en), .master_i(mst),
		.clock_phase_i(cpha), .clock_polarity_select_i(cpol), .ss_out_en_i(soe),
		.multi_master_i(mm), .tx_start_i(go), .tx_data_i(txd), .busy_o(busy),
		.rx_valid_o(vld), .rx_data_o(rxd), .fault_clear_i(fclr), .mode_fault_o(mf),
		.sck_in_i(sck), .sck_out_o(sck_o), .sck_oe_o(sck_e), .mosi_in_i(mosi),
		.mosi_out_o(mosi_o), .mosi_oe_o(mosi_e), .miso_in_i(miso), .miso_out_o(miso_o),
		.miso_oe_o(miso_e), .ss_n_in_i(ss_n), .ss_n_out_o(sso_n), .ss_n_oe_o(sse));
	spims_slave_model i_spims_slave_model (.sck_i(sck), .ss_n_i(ss_n | ~mst),
		.mosi_i(mosi), .cpha_i(cpha), .cpol_i(cpol), .tx_i(stx), .miso_o(smiso), .rx_o(srx));
	task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask
	task automatic end_of_test;
		if (errors == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Bounded wait for one more received byte
	task automatic wait_rx(int n0);
		int k;
		for (k = 0; k < 300 && nv == n0; k++) @(negedge clk_sys_i);
		if (k == 300) begin
			chk("rx timeout", 8'h01, 8'h00);
			end_of_test;
		end
	endtask
	task automatic mxfer(logic [7:0] d, logic [7:0] m);
		int n0;
		n0 = nv;
		txd = d;
		stx = m;
		// With the select pin left as input the bench selects the slave itself
		tss_n = soe;
		go = 1;
		@(negedge clk_sys_i) go = 0;
		wait_rx(n0);
		chk("master rx", rxd, m);
		chk("slave rx", srx, d);
		chk("select oe", {7'h00, sse}, {7'h00, soe});
		tss_n = 1;
	endtask
	// Bench as master on the 160 ns link clock
	task automatic sxfer(logic [7:0] d, logic [7:0] m, logic rel);
		logic [7:0] got;
		int n0;
		n0 = nv;
		txd = m;
		tss_n = 0;
		#160;
		for (int b = 7; b >= 0; b--) begin
			if (cpha) tsck = ~tsck;
			tmosi = d[b];
			#80 tsck = ~tsck;
			got[b] = miso;
			#80 if (!cpha) tsck = ~tsck;
		end
		tss_n = rel;
		tmosi = ~tmosi;
		wait_rx(n0);
		chk("port rx", rxd, d);
		chk("port tx", got, m);
	endtask
	initial begin
		logic [7:0] m;
		void'($urandom(27));
		repeat (4) @(posedge clk_sys_i);
		@(negedge clk_sys_i) rst_n_i = 1;
		en = 1;
		// Every clock mode as master, end bits first, then random bytes
		for (int i = 0; i < 16; i++) begin
			{cpha, cpol} = 2'(i);
			soe = (i != 5);
			repeat (2) @(negedge clk_sys_i);
			mxfer(i < 4 ? 8'h80 : 8'($urandom), i < 4 ? 8'h01 : 8'($urandom));
		end
		// Another master pulls select low: fault, refused start, clear
		mm = 1;
		tss_n = 0;
		repeat (6) @(negedge clk_sys_i);
		chk("fault", {7'h00, mf}, 8'h01);
		go = 1;
		repeat (3) @(negedge clk_sys_i);
		chk("busy", {7'h00, busy}, 8'h00);
		go = 0;
		tss_n = 1;
		fclr = 1;
		repeat (4) @(negedge clk_sys_i);
		fclr = 0;
		chk("cleared", {7'h00, mf}, 8'h00);
		// Slave mode, select held across two bytes then released
		mm = 0;
		mst = 0;
		for (int i = 0; i < 4; i++) begin
			{cpha, cpol} = 2'(i);
			tsck = cpol;
			m = 8'($urandom);
			repeat (4) @(negedge clk_sys_i);
			sxfer(8'($urandom), m, 1'b0);
			sxfer(8'($urandom), m, 1'b1);
		end
		end_of_test;
	end
endmodule // tb_top
